// ### shared/lpb_pkg.sv
package lpb_pkg;

    // ----------------------------------------------------------------
    // Register map and field layout
    // ----------------------------------------------------------------
    localparam int LPB_NUM_REGS = 35;
    localparam int LPB_SHARED_BLOCKS = 16;
    localparam logic [5:0] LPB_TOP_BLOCK = 6'h31;
    localparam logic [5:0] LPB_FIRST_OWN_BLOCK = 6'h10;
    localparam logic [5:0] LPB_REG_BASE_SHIFT = 6'h0f;

    // Index 0 serves blocks 0 to 15, index n serves block n + 15
    localparam logic [LPB_NUM_REGS-1:0][31:0] LPB_LOCK_ADDR = {
        32'hffbfc002, 32'hffbfa002, 32'hffbf8002, 32'hffbf0002, 32'hffbe0002,
        32'hffbd0002, 32'hffbc0002, 32'hffbb0002, 32'hffba0002, 32'hffb90002,
        32'hffb80002, 32'hffb70002, 32'hffb60002, 32'hffb50002, 32'hffb40002,
        32'hffb30002, 32'hffb20002, 32'hffb10002, 32'hffb00002, 32'hffaf0002,
        32'hffae0002, 32'hffad0002, 32'hffac0002, 32'hffab0002, 32'hffaa0002,
        32'hffa90002, 32'hffa80002, 32'hffa70002, 32'hffa60002, 32'hffa50002,
        32'hffa40002, 32'hffa30002, 32'hffa20002, 32'hffa10002, 32'hffa00002
    };
    localparam logic [31:0] LPB_MAKER_ID_ADDR = 32'hffbc0000;
    localparam logic [31:0] LPB_PART_ID_ADDR = 32'hffbc0001;
    localparam logic [31:0] LPB_INPUT_SNAP_ADDR = 32'hffbc0100;

    localparam int LPB_WRITE_LOCK_BIT = 0;
    localparam int LPB_LOCK_DOWN_BIT = 1;
    localparam int LPB_READ_LOCK_BIT = 2;
    localparam logic [7:0] LPB_LOCK_RESET = 8'h01;
    localparam logic [7:0] LPB_READ_BLANK = 8'h00;

    localparam int LPB_GPI_WIDTH = 5;
    localparam int LPB_ID_WIDTH = 4;
    localparam logic [LPB_ID_WIDTH-1:0] LPB_BOOT_ID = 4'h0;

    // Arbitrary identification values, not tied to any real part
    localparam logic [7:0] LPB_MAKER_ID_DEFAULT = 8'h5a;
    localparam logic [7:0] LPB_PART_ID_DEFAULT = 8'h6b;

endpackage

// ### rtl/lpb_sync.sv
`timescale 1ns/1ps

module lpb_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } lpb_sync_state_t;

    lpb_sync_state_t st;
    lpb_sync_state_t next_st;

    // ----------------------------------------------------------------
    // Two-stage synchroniser, low after reset
    // ----------------------------------------------------------------
    always_comb begin
        next_st.first = pinIn;
        next_st.second = st.first;
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign pinOut = st.second;

endmodule

// ### rtl/lpb_regs.sv
`timescale 1ns/1ps

module lpb_regs
    import lpb_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = LPB_MAKER_ID_DEFAULT,
    parameter logic [7:0] PART_ID = LPB_PART_ID_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic interfaceResetPin_n,
    input wire logic cpuResetPin_n,
    input wire logic topBlockProtectPin_n,
    input wire logic writeProtectPin_n,
    input wire logic [LPB_GPI_WIDTH-1:0] generalInputPins,
    input wire logic [LPB_ID_WIDTH-1:0] identificationInputs,
    input wire logic regReq,
    input wire logic regWe,
    input wire logic [31:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic regAck,
    output logic regHit,
    output logic [7:0] regRdata,
    input wire logic arrayOpReq,
    input wire logic [5:0] arrayOpBlock,
    output logic arrayOpGrant,
    output logic arrayOpDeny,
    input wire logic clearStatus,
    output logic blockProtStatus,
    input wire logic arrayReadReq,
    input wire logic [5:0] arrayReadBlock,
    input wire logic [7:0] arrayReadData,
    output logic arrayReadValid,
    output logic [7:0] arrayReadOut
);

    typedef struct packed {
        logic [LPB_NUM_REGS-1:0] wrLock;
        logic [LPB_NUM_REGS-1:0] rdLock;
        logic [LPB_NUM_REGS-1:0] lkDown;
        logic ack;
        logic hit;
        logic [7:0] rdata;
        logic opGrant;
        logic opDeny;
        logic protStatus;
        logic rdValid;
        logic [7:0] rdOut;
    } lpb_state_t;

    localparam int SYNC_WIDTH = LPB_GPI_WIDTH + LPB_ID_WIDTH + 4;

    lpb_state_t st;
    lpb_state_t next_st;
    logic [SYNC_WIDTH-1:0] syncOut;
    logic [LPB_GPI_WIDTH-1:0] gpiLevel;
    logic [LPB_ID_WIDTH-1:0] idLevel;
    logic tblLevel_n;
    logic wpLevel_n;
    logic intfRstLevel_n;
    logic cpuRstLevel_n;
    logic hwRst;
    logic bootCfg;
    logic [LPB_NUM_REGS-1:0] lockHit;
    logic [5:0] opIdx;
    logic [5:0] rdIdx;
    logic opProtected;

    // ----------------------------------------------------------------
    // Pin synchronisers and combined reset
    // ----------------------------------------------------------------
    lpb_sync #(
        .WIDTH(SYNC_WIDTH)
    ) u_pin_sync (
        .mclk(mclk),
        .rst(rst),
        .pinIn({generalInputPins, identificationInputs, topBlockProtectPin_n,
                writeProtectPin_n, interfaceResetPin_n, cpuResetPin_n}),
        .pinOut(syncOut)
    );

    assign gpiLevel = syncOut[SYNC_WIDTH-1 -: LPB_GPI_WIDTH];
    assign idLevel = syncOut[LPB_ID_WIDTH+3 -: LPB_ID_WIDTH];
    assign tblLevel_n = syncOut[3];
    assign wpLevel_n = syncOut[2];
    assign intfRstLevel_n = syncOut[1];
    assign cpuRstLevel_n = syncOut[0];

    // Either reset pin sets the write-lock bits and clears the read-lock and lock-down bits
    assign hwRst = rst | ~intfRstLevel_n | ~cpuRstLevel_n;
    assign bootCfg = (idLevel == LPB_BOOT_ID);

    // ----------------------------------------------------------------
    // Address and block decoding
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < LPB_NUM_REGS; gi++) begin : g_hit
            assign lockHit[gi] = bootCfg && (regAddr == LPB_LOCK_ADDR[gi]);
        end
    endgenerate

    // Lock register index that guards a block
    function automatic logic [5:0] lpb_block_reg(input logic [5:0] blk);
        if (blk < LPB_FIRST_OWN_BLOCK) begin
            lpb_block_reg = 6'h00;
        end else begin
            lpb_block_reg = blk - LPB_REG_BASE_SHIFT;
        end
    endfunction

    assign opIdx = lpb_block_reg(arrayOpBlock);
    assign rdIdx = lpb_block_reg(arrayReadBlock);

    // Register bits, pins, or a nonexistent block all protect
    always_comb begin
        if (arrayOpBlock > LPB_TOP_BLOCK) begin
            opProtected = 1'b1;
        end else if (arrayOpBlock == LPB_TOP_BLOCK) begin
            opProtected = st.wrLock[opIdx] | ~tblLevel_n;
        end else begin
            opProtected = st.wrLock[opIdx] | ~wpLevel_n;
        end
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = regReq;
        next_st.hit = 1'b0;
        next_st.rdata = 8'h00;
        next_st.opGrant = 1'b0;
        next_st.opDeny = 1'b0;
        next_st.rdValid = arrayReadReq;
        next_st.rdOut = st.rdOut;

        if (regReq) begin
            for (int i = 0; i < LPB_NUM_REGS; i++) begin
                if (lockHit[i]) begin
                    next_st.hit = 1'b1;
                    // Reserved bits 7 to 3 read zero
                    next_st.rdata = {5'h00, st.rdLock[i], st.lkDown[i], st.wrLock[i]};
                    if (regWe && !st.lkDown[i]) begin
                        next_st.wrLock[i] = regWdata[LPB_WRITE_LOCK_BIT];
                        next_st.rdLock[i] = regWdata[LPB_READ_LOCK_BIT];
                        next_st.lkDown[i] = regWdata[LPB_LOCK_DOWN_BIT];
                    end
                end
            end
            if (bootCfg && regAddr == LPB_MAKER_ID_ADDR) begin
                next_st.hit = 1'b1;
                next_st.rdata = MAKER_ID;
            end
            if (bootCfg && regAddr == LPB_PART_ID_ADDR) begin
                next_st.hit = 1'b1;
                next_st.rdata = PART_ID;
            end
            if (bootCfg && regAddr == LPB_INPUT_SNAP_ADDR) begin
                next_st.hit = 1'b1;
                // Pins sampled at request; host keeps them steady over the cycle
                next_st.rdata = {3'h0, gpiLevel};
            end
        end

        if (arrayOpReq) begin
            next_st.opGrant = ~opProtected;
            next_st.opDeny = opProtected;
        end

        // Set wins over a simultaneous clear
        if (clearStatus) begin
            next_st.protStatus = 1'b0;
        end
        if (arrayOpReq && opProtected) begin
            next_st.protStatus = 1'b1;
        end

        if (arrayReadReq) begin
            if (st.rdLock[rdIdx]) begin
                next_st.rdOut = LPB_READ_BLANK;
            end else begin
                next_st.rdOut = arrayReadData;
            end
        end

        if (hwRst) begin
            next_st = '0;
            next_st.wrLock = '1;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign regAck = st.ack;
    assign regHit = st.hit;
    assign regRdata = st.rdata;
    assign arrayOpGrant = st.opGrant;
    assign arrayOpDeny = st.opDeny;
    assign blockProtStatus = st.protStatus;
    assign arrayReadValid = st.rdValid;
    assign arrayReadOut = st.rdOut;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_gpi_read_value: assert property (@(posedge mclk) disable iff (hwRst)
        regReq && !regWe && bootCfg && regAddr == LPB_INPUT_SNAP_ADDR
        |=> regAck && regHit && regRdata == {3'h0, $past(gpiLevel)})
        else $error("input register read returned wrong levels");

    chk_gpi_write_inert: assert property (@(posedge mclk) disable iff (hwRst)
        regReq && regWe && regAddr == LPB_INPUT_SNAP_ADDR
        |=> $stable(st.wrLock) && $stable(st.rdLock) && $stable(st.lkDown))
        else $error("write to input register changed lock state");

    chk_lockdown_sticky: assert property (@(posedge mclk) disable iff (hwRst)
        ((~st.lkDown) & $past(st.lkDown)) == '0)
        else $error("lock-down cleared without reset");

    chk_frozen_bits: assert property (@(posedge mclk) disable iff (hwRst)
        (((st.wrLock ^ $past(st.wrLock)) | (st.rdLock ^ $past(st.rdLock)))
         & $past(st.lkDown)) == '0)
        else $error("locked register bits changed");

    chk_write_update: assert property (@(posedge mclk) disable iff (hwRst)
        regReq && regWe && lockHit[0] && !st.lkDown[0]
        |=> st.wrLock[0] == $past(regWdata[0]) && st.rdLock[0] == $past(regWdata[2])
            && regHit ##1 st.wrLock[0] == $past(st.wrLock[0]))
        else $error("unlocked write did not update bits");

    chk_read_blank: assert property (@(posedge mclk) disable iff (hwRst)
        arrayReadReq && st.rdLock[rdIdx] |=> arrayReadValid && arrayReadOut == 8'h00)
        else $error("read-locked block returned data");

    chk_read_pass: assert property (@(posedge mclk) disable iff (hwRst)
        arrayReadReq && !st.rdLock[rdIdx]
        |=> arrayReadValid && arrayReadOut == $past(arrayReadData))
        else $error("unlocked block read altered");

    chk_lock_denies: assert property (@(posedge mclk) disable iff (hwRst)
        arrayOpReq && st.wrLock[opIdx] |=> arrayOpDeny && !arrayOpGrant && blockProtStatus)
        else $error("write-locked block not denied");

    chk_unlock_grants: assert property (@(posedge mclk) disable iff (hwRst)
        arrayOpReq && !st.wrLock[opIdx] && wpLevel_n && arrayOpBlock < LPB_TOP_BLOCK
        |=> arrayOpGrant && !arrayOpDeny)
        else $error("unlocked block not granted");

    chk_top_pin: assert property (@(posedge mclk) disable iff (hwRst)
        arrayOpReq && arrayOpBlock == LPB_TOP_BLOCK && !tblLevel_n |=> arrayOpDeny)
        else $error("top block not protected by pin");

    chk_wp_pin: assert property (@(posedge mclk) disable iff (hwRst)
        arrayOpReq && arrayOpBlock < LPB_TOP_BLOCK && !wpLevel_n |=> arrayOpDeny)
        else $error("block not protected by write-protect pin");

    chk_status_holds: assert property (@(posedge mclk) disable iff (hwRst)
        blockProtStatus && !clearStatus |=> blockProtStatus)
        else $error("protection status dropped without clear");

    chk_reset_default: assert property (@(posedge mclk) disable iff (1'b0)
        hwRst |=> st.wrLock == '1 && st.rdLock == '0 && st.lkDown == '0 && !blockProtStatus)
        else $error("lock registers not at default after reset");

    chk_reserved_zero: assert property (@(posedge mclk) disable iff (hwRst)
        regReq && !regWe && lockHit != '0 |=> regRdata[7:3] == 5'h00)
        else $error("reserved lock bits read non-zero");

endmodule

// ### tb/lpb_host_model.sv
`timescale 1ns/1ps

module lpb_host_model (
    input wire logic mclk,
    input wire logic regAck,
    input wire logic regHit,
    input wire logic [7:0] regRdata,
    output logic regReq,
    output logic regWe,
    output logic [31:0] regAddr,
    output logic [7:0] regWdata
);
    initial begin
        regReq = 1'b0;
        regWe = 1'b0;
        regAddr = 32'h00000000;
        regWdata = 8'h00;
    end

    // One request pulse, then a bounded wait for the acknowledge
    task automatic access(input logic we, input logic [31:0] addr, input logic [7:0] wdata,
            output logic hit, output logic [7:0] rdata, output logic ok);
        int i;
        ok = 1'b0;
        hit = 1'b0;
        rdata = 8'h00;
        @(posedge mclk);
        regReq <= 1'b1;
        regWe <= we;
        regAddr <= addr;
        regWdata <= wdata;
        @(posedge mclk);
        regReq <= 1'b0;
        // Released lines show the inverse so stale values cannot pass
        regAddr <= ~addr;
        regWdata <= ~wdata;
        for (i = 0; i < 8 && !ok; i++) begin
            @(posedge mclk);
            if (regAck === 1'b1) begin
                ok = 1'b1;
                hit = regHit;
                rdata = regRdata;
            end
        end
    endtask
endmodule

// ### tb/lpb_regs_test.sv
`timescale 1ns/1ps

module lpb_regs_test;
    import lpb_pkg::*;
    logic mclk, rst, interfaceResetPin_n, cpuResetPin_n;
    logic topBlockProtectPin_n, writeProtectPin_n;
    logic [LPB_GPI_WIDTH-1:0] generalInputPins;
    logic [LPB_ID_WIDTH-1:0] identificationInputs;
    logic regReq, regWe, regAck, regHit;
    logic [31:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic arrayOpReq, arrayOpGrant, arrayOpDeny, clearStatus, blockProtStatus;
    logic [5:0] arrayOpBlock, arrayReadBlock;
    logic arrayReadReq, arrayReadValid;
    logic [7:0] arrayReadData, arrayReadOut;
    int numErrors = 0;
    int nChecks = 0;

    lpb_regs DUT (.mclk(mclk), .rst(rst), .interfaceResetPin_n(interfaceResetPin_n),
        .cpuResetPin_n(cpuResetPin_n), .topBlockProtectPin_n(topBlockProtectPin_n),
        .writeProtectPin_n(writeProtectPin_n), .generalInputPins(generalInputPins),
        .identificationInputs(identificationInputs), .regReq(regReq), .regWe(regWe),
        .regAddr(regAddr), .regWdata(regWdata), .regAck(regAck), .regHit(regHit),
        .regRdata(regRdata), .arrayOpReq(arrayOpReq), .arrayOpBlock(arrayOpBlock),
        .arrayOpGrant(arrayOpGrant), .arrayOpDeny(arrayOpDeny), .clearStatus(clearStatus),
        .blockProtStatus(blockProtStatus), .arrayReadReq(arrayReadReq),
        .arrayReadBlock(arrayReadBlock), .arrayReadData(arrayReadData),
        .arrayReadValid(arrayReadValid), .arrayReadOut(arrayReadOut));

    lpb_host_model HOST (.mclk(mclk), .regAck(regAck), .regHit(regHit), .regRdata(regRdata),
        .regReq(regReq), .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // Checking and access tasks
    // ----------------------------------------------------------------
    task automatic finalReport;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic we, input logic [31:0] a, input logic [7:0] d,
            input logic eHit, input logic [7:0] eData);
        logic h, ok;
        logic [7:0] q;
        HOST.access(we, a, d, h, q, ok);
        if (!ok) begin
            numErrors++;
            finalReport();
        end
        chk1(h, eHit);
        if (!we) begin
            chk8(q, eData);
        end
    endtask

    task automatic waitCy(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic op(input logic [5:0] b, input logic g, input logic st);
        @(posedge mclk);
        arrayOpReq <= 1'b1;
        arrayOpBlock <= b;
        @(posedge mclk);
        arrayOpReq <= 1'b0;
        arrayOpBlock <= ~b;
        @(posedge mclk);
        chk1(arrayOpGrant, g);
        chk1(arrayOpDeny, !g);
        chk1(blockProtStatus, st);
    endtask

    task automatic clr;
        @(posedge mclk);
        clearStatus <= 1'b1;
        @(posedge mclk);
        clearStatus <= 1'b0;
        @(posedge mclk);
        chk1(blockProtStatus, 1'b0);
    endtask

    task automatic ard(input logic [5:0] b, input logic [7:0] d, input logic [7:0] e);
        @(posedge mclk);
        arrayReadReq <= 1'b1;
        arrayReadBlock <= b;
        arrayReadData <= d;
        @(posedge mclk);
        arrayReadReq <= 1'b0;
        arrayReadData <= ~d;
        @(posedge mclk);
        chk1(arrayReadValid, 1'b1);
        chk8(arrayReadOut, e);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        numErrors++;
        finalReport();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {interfaceResetPin_n, cpuResetPin_n, topBlockProtectPin_n, writeProtectPin_n} = 4'hf;
        generalInputPins = 5'h00;
        identificationInputs = 4'h0;
        {arrayOpReq, clearStatus, arrayReadReq} = 3'h0;
        {arrayOpBlock, arrayReadBlock, arrayReadData} = 20'h00000;
        waitCy(3);
        rst <= 1'b0;
        waitCy(4);
        for (int i = 0; i < LPB_NUM_REGS; i++) begin
            acc(0, LPB_LOCK_ADDR[i], 8'h00, 1, LPB_LOCK_RESET);
        end
        acc(1, LPB_LOCK_ADDR[1], 8'hff, 1, 8'h00);
        acc(0, LPB_LOCK_ADDR[1], 8'h00, 1, 8'h07);
        acc(1, LPB_LOCK_ADDR[1], 8'h00, 1, 8'h00);
        acc(0, LPB_LOCK_ADDR[1], 8'h00, 1, 8'h07);
        op(6'h10, 0, 1);
        clr();
        acc(1, LPB_LOCK_ADDR[2], 8'hf8, 1, 8'h00);
        acc(0, LPB_LOCK_ADDR[2], 8'h00, 1, 8'h00);
        op(6'h11, 1, 0);
        acc(1, LPB_LOCK_ADDR[2], 8'h04, 1, 8'h00);
        acc(0, LPB_LOCK_ADDR[2], 8'h00, 1, 8'h04);
        ard(6'h11, 8'ha5, 8'h00);
        ard(6'h12, 8'h5a, 8'h5a);
        acc(1, LPB_LOCK_ADDR[0], 8'h00, 1, 8'h00);
        op(6'h00, 1, 0);
        op(6'h0f, 1, 0);
        acc(1, LPB_LOCK_ADDR[34], 8'h00, 1, 8'h00);
        writeProtectPin_n <= 1'b0;
        waitCy(3);
        op(6'h0f, 0, 1);
        clr();
        op(LPB_TOP_BLOCK, 1, 0);
        writeProtectPin_n <= 1'b1;
        topBlockProtectPin_n <= 1'b0;
        waitCy(3);
        op(LPB_TOP_BLOCK, 0, 1);
        topBlockProtectPin_n <= 1'b1;
        cpuResetPin_n <= 1'b0;
        waitCy(4);
        cpuResetPin_n <= 1'b1;
        waitCy(4);
        chk1(blockProtStatus, 1'b0);
        acc(0, LPB_LOCK_ADDR[1], 8'h00, 1, 8'h01);
        acc(1, LPB_LOCK_ADDR[1], 8'h03, 1, 8'h00);
        interfaceResetPin_n <= 1'b0;
        waitCy(4);
        interfaceResetPin_n <= 1'b1;
        waitCy(4);
        acc(0, LPB_LOCK_ADDR[1], 8'h00, 1, 8'h01);
        acc(1, LPB_MAKER_ID_ADDR, 8'h00, 1, 8'h00);
        acc(0, LPB_MAKER_ID_ADDR, 8'h00, 1, LPB_MAKER_ID_DEFAULT);
        acc(1, LPB_PART_ID_ADDR, 8'h00, 1, 8'h00);
        acc(0, LPB_PART_ID_ADDR, 8'h00, 1, LPB_PART_ID_DEFAULT);
        // Pins stay put across each register read
        generalInputPins <= 5'h15;
        waitCy(3);
        acc(0, LPB_INPUT_SNAP_ADDR, 8'h00, 1, 8'h15);
        acc(1, LPB_INPUT_SNAP_ADDR, 8'hff, 1, 8'h00);
        acc(0, LPB_INPUT_SNAP_ADDR, 8'h00, 1, 8'h15);
        generalInputPins <= 5'h0a;
        waitCy(3);
        acc(0, LPB_INPUT_SNAP_ADDR, 8'h00, 1, 8'h0a);
        acc(0, 32'hffbc0003, 8'h00, 0, 8'h00);
        identificationInputs <= 4'h1;
        waitCy(3);
        acc(0, LPB_LOCK_ADDR[0], 8'h00, 0, 8'h00);
        identificationInputs <= 4'h0;
        waitCy(3);
        acc(0, LPB_LOCK_ADDR[0], 8'h00, 1, 8'h01);
        finalReport();
    end
endmodule
